// >>> dacc_core.sv
// Dual channel conversion core: state control, saturation, averaging
`timescale 1ns/100ps
module dacc_core #(
	parameter int RES = 16,
	parameter int CONV_CYCLES = dacc_pkg::CONV_CYCLES
) (
	// Clock and reset
	input  wire logic           core_clk_i,
	input  wire logic           rst_i,
	// Host control pins
	input  wire logic           conversion_start_pin_i,
	input  wire logic           powerdown_reset_pin_i,
	// Configuration
	input  wire logic [1:0]     averaging_select_field_i,
	input  wire logic           mid_reference_offset_enable_i,
	// Raw converter results, signed, wider than result
	input  wire logic [RES+1:0] raw_a_i,
	input  wire logic [RES+1:0] raw_b_i,
	// Analog control and outputs
	output logic                sample_switch_closed_o,
	output logic [7:0]          mid_reference_buffer_offset_o,
	output logic                conversion_done_internal_o,
	output logic                ready_o,
	output logic [RES-1:0]      data_a_o,
	output logic [RES-1:0]      data_b_o
);
	// Only the two resolutions have full-scale codes defined
	if (RES != 16 && RES != 14) begin
		$error("RES must be 16 or 14");
	end
	// Down counter is eight bits wide
	if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin
		$error("CONV_CYCLES out of range");
	end

	localparam logic signed [RES+1:0] POS_FULL_SCALE = (RES+2)'((1 << (RES-1)) - 1);
	localparam logic signed [RES+1:0] NEG_FULL_SCALE = -(RES+2)'(1 << (RES-1));

	logic [1:0] cs_sync, pd_sync;
	logic       cs_prev, pd_prev;
	logic       cs_rise, pd_fall;
	dacc_pkg::dacc_state_t st_reg, st_next;
	logic [7:0] cnt_reg, cnt_next;
	logic       done_reg, done_next;
	logic       sw_reg, sw_next;
	logic [RES-1:0] res_a_reg, res_a_next, res_b_reg, res_b_next;
	logic [1:0] sel_reg;
	logic [7:0] ofs_reg, ofs_next;
	logic       clr;
	logic       va, vb;
	logic [RES-1:0] aa, ab;

	function automatic logic [RES-1:0] sat(input logic signed [RES+1:0] v);
		if (v > POS_FULL_SCALE)
			sat = RES'(POS_FULL_SCALE); // RULE7 RULE8
		else if (v < NEG_FULL_SCALE)
			sat = RES'(NEG_FULL_SCALE); // RULE7
		else
			sat = RES'(v); // RULE6
	endfunction

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cs_sync <= 2'h0;
			pd_sync <= 2'h3;
			cs_prev <= 1'b0;
			pd_prev <= 1'b1;
		end else begin
			cs_sync <= {cs_sync[0], conversion_start_pin_i};
			pd_sync <= {pd_sync[0], powerdown_reset_pin_i};
			cs_prev <= cs_sync[1];
			pd_prev <= pd_sync[1];
		end
	end

	assign cs_rise = cs_sync[1] & ~cs_prev;
	assign pd_fall = ~pd_sync[1] & pd_prev;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		sw_next = sw_reg;
		res_a_next = res_a_reg;
		res_b_next = res_b_reg;
		ofs_next = mid_reference_offset_enable_i ? dacc_pkg::OFFSET_CODE : 8'h00; // RULE9
		case (st_reg)
			dacc_pkg::ST_RST: begin
				sw_next = 1'b1;
				if (pd_sync[1])
					st_next = dacc_pkg::ST_ACQ;
			end
			dacc_pkg::ST_ACQ: begin
				if (pd_fall) begin
					st_next = dacc_pkg::ST_RST; // RULE13
				end else if (cs_rise) begin
					st_next = dacc_pkg::ST_CNV; // RULE1
					sw_next = 1'b0; // RULE3
					cnt_next = 8'(CONV_CYCLES - 1); // RULE2
				end
			end
			dacc_pkg::ST_CNV: begin
				if (pd_fall) begin
					st_next = dacc_pkg::ST_RST; // RULE13
					sw_next = 1'b1;
				end else if (cnt_reg == 8'h00) begin
					st_next = dacc_pkg::ST_ACQ; // RULE4
					sw_next = 1'b1;
					done_next = 1'b1; // RULE5
					res_a_next = sat(raw_a_i);
					res_b_next = sat(raw_b_i);
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: st_next = dacc_pkg::ST_RST;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= dacc_pkg::ST_RST;
			cnt_reg <= 8'h00;
			done_reg <= 1'b0;
			sw_reg <= 1'b1;
			res_a_reg <= '0;
			res_b_reg <= '0;
			sel_reg <= 2'h0;
			ofs_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
			sw_reg <= sw_next;
			res_a_reg <= res_a_next;
			res_b_reg <= res_b_next;
			sel_reg <= averaging_select_field_i;
			ofs_reg <= ofs_next;
		end
	end

	// Partial averages are dropped on reset or a setting change
	assign clr = (st_reg == dacc_pkg::ST_RST) || (sel_reg != averaging_select_field_i); // RULE15

	dacc_avg #(.RES(RES)) u_avg_a (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.clear_i     (clr),
		.avg_sel_i   (sel_reg),
		.sample_vld_i(done_reg),
		.sample_i    (res_a_reg),
		.avg_vld_o   (va),
		.avg_o       (aa)
	);

	dacc_avg #(.RES(RES)) u_avg_b (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.clear_i     (clr),
		.avg_sel_i   (sel_reg),
		.sample_vld_i(done_reg),
		.sample_i    (res_b_reg),
		.avg_vld_o   (vb),
		.avg_o       (ab)
	);

	assign sample_switch_closed_o = sw_reg;
	assign mid_reference_buffer_offset_o = ofs_reg;
	assign conversion_done_internal_o = done_reg;
	assign ready_o = va;
	assign data_a_o = aa;
	assign data_b_o = ab;

	// Samples taken since the last ready, counted apart from the averager to check its pairing
	logic [2:0] seen_reg, seen_next;

	always_comb begin
		seen_next = va ? 3'h0 : seen_reg;
		if (done_reg)
			seen_next = seen_next + 3'h1;
		if (clr)
			seen_next = 3'h0;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			seen_reg <= 3'h0;
		end else begin
			seen_reg <= seen_next;
		end
	end

	a_start_conv: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1
		(st_reg == dacc_pkg::ST_ACQ && cs_rise && !pd_fall) |=> (st_reg == dacc_pkg::ST_CNV))
		else $error("Start missed");
	a_conv_count: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE2
		(st_reg == dacc_pkg::ST_ACQ && cs_rise && !pd_fall) |=> (cnt_reg == 8'(CONV_CYCLES - 1)))
		else $error("Conversion count not loaded");
	a_switch_open: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE3
		(st_reg == dacc_pkg::ST_CNV) |-> !sw_reg)
		else $error("Inputs connected while converting");
	a_conv_done: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE4
		(st_reg == dacc_pkg::ST_CNV && cnt_reg == 8'h00 && !pd_fall)
		|=> (done_reg && sw_reg && st_reg == dacc_pkg::ST_ACQ))
		else $error("Conversion end wrong");
	a_done_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE5
		done_reg |=> !done_reg)
		else $error("Done not a pulse");
	a_sat_range: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE7
		(st_reg == dacc_pkg::ST_CNV && cnt_reg == 8'h00 && !pd_fall && $signed(raw_a_i) > POS_FULL_SCALE)
		|=> (res_a_reg == RES'(POS_FULL_SCALE)))
		else $error("Result beyond full scale");
	a_sat_low: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE7
		(st_reg == dacc_pkg::ST_CNV && cnt_reg == 8'h00 && !pd_fall && $signed(raw_b_i) < NEG_FULL_SCALE)
		|=> (res_b_reg == RES'(NEG_FULL_SCALE)))
		else $error("Result below full scale");
	a_abort_conv: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE13
		(st_reg == dacc_pkg::ST_CNV && pd_fall) |=> (st_reg == dacc_pkg::ST_RST && !done_reg))
		else $error("Abort failed");
	a_offset_en: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE9
		mid_reference_offset_enable_i |=> (ofs_reg == dacc_pkg::OFFSET_CODE))
		else $error("Offset missing");
	a_ready_two: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE11
		(va && sel_reg == dacc_pkg::AVG_TWO) |-> (seen_reg == 3'h2))
		else $error("Ready without two samples");
	a_ready_four: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE12
		(va && sel_reg == dacc_pkg::AVG_FOUR) |-> (seen_reg == 3'h4))
		else $error("Ready without four samples");
	c_conv: cover property (@(posedge core_clk_i) done_reg);
	c_abort: cover property (@(posedge core_clk_i) st_reg == dacc_pkg::ST_CNV && pd_fall);
	c_avg2: cover property (@(posedge core_clk_i) va && sel_reg == dacc_pkg::AVG_TWO);
	c_avg4: cover property (@(posedge core_clk_i) va && sel_reg == dacc_pkg::AVG_FOUR);
	c_sat: cover property (@(posedge core_clk_i) done_reg && res_a_reg == RES'(POS_FULL_SCALE));
endmodule

// >>> dacc_pkg.sv
// Constants shared by the dual converter conversion core
// How it works
// RULE1 - A start rising edge begins conversion of both channels together.
// RULE2 - Conversion is timed by the internal clock only; no host clock used.
// RULE3 - Inputs stay disconnected from sampling capacitors while converting.
// RULE4 - Conversion end reconnects inputs and returns to acquisition.
// RULE5 - Converter takes reset and start, returns done pulse plus result.
// RULE6 - Results are two's complement, 16 or 14 bits wide.
// RULE7 - Saturate: negative full scale 8000/2000 hex, positive 7FFF, mid zero.
// RULE8 - 14-bit positive full scale is 1FFF hex, mid-scale 0000.
// RULE9 - Offset-enable bit at one raises mid-reference buffer by 100 mV.
// RULE10 - Optionally average two or four samples per averaging config.
// RULE11 - Select 10b: mean of two, ready after second start edge.
// RULE12 - Select 11b: mean of four, ready after fourth start edge.
// RULE13 - Powerdown/reset falling edge forces reset state, aborting conversion.
// RULE14 - Sum signed samples wide, divide by arithmetic shift.
// RULE15 - Accumulator and counter clear on reset and averaging change.
package dacc_pkg;
	localparam int CONV_TIME_NS = 200;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] AVG_OFF_A = 2'h0;
	localparam logic [1:0] AVG_OFF_B = 2'h1;
	localparam logic [1:0] AVG_TWO = 2'h2;
	localparam logic [1:0] AVG_FOUR = 2'h3;
	localparam int OFFSET_MV = 100;
	localparam logic [7:0] OFFSET_CODE = 8'h64;
	typedef enum logic [1:0] {
		ST_RST,
		ST_ACQ,
		ST_CNV
	} dacc_state_t;
endpackage

// >>> dacc_avg.sv
// Averaging of successive signed samples for one channel
`timescale 1ns/100ps
module dacc_avg #(
	parameter int RES = 16
) (
	input  wire logic           core_clk_i,
	input  wire logic           rst_i,
	input  wire logic           clear_i,
	input  wire logic [1:0]     avg_sel_i,
	input  wire logic           sample_vld_i,
	input  wire logic [RES-1:0] sample_i,
	output logic                avg_vld_o,
	output logic [RES-1:0]      avg_o
);
	logic signed [RES+1:0] acc_reg, acc_next;
	logic [1:0]            cnt_reg, cnt_next;
	logic                  vld_reg, vld_next;
	logic [RES-1:0]        out_reg, out_next;
	logic signed [RES+1:0] sum;
	logic [1:0]            last;

	if (RES < 2) begin
		$error("RES too small for the averager");
	end

	always_comb begin
		sum = acc_reg + {{2{sample_i[RES-1]}}, sample_i}; // RULE14
		last = (avg_sel_i == dacc_pkg::AVG_FOUR) ? 2'h3 : (avg_sel_i == dacc_pkg::AVG_TWO) ? 2'h1 : 2'h0;
		acc_next = acc_reg;
		cnt_next = cnt_reg;
		vld_next = 1'b0;
		out_next = out_reg;
		if (clear_i) begin
			acc_next = '0; // RULE15
			cnt_next = 2'h0;
		end else if (sample_vld_i) begin
			if (cnt_reg == last) begin
				vld_next = 1'b1; // RULE10 RULE11 RULE12
				acc_next = '0;
				cnt_next = 2'h0;
				if (last == 2'h3)
					out_next = RES'(sum >>> 2); // RULE14
				else if (last == 2'h1)
					out_next = RES'(sum >>> 1);
				else
					out_next = sample_i;
			end else begin
				acc_next = sum;
				cnt_next = cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			acc_reg <= '0;
			cnt_reg <= 2'h0;
			vld_reg <= 1'b0;
			out_reg <= '0;
		end else begin
			acc_reg <= acc_next;
			cnt_reg <= cnt_next;
			vld_reg <= vld_next;
			out_reg <= out_next;
		end
	end

	assign avg_vld_o = vld_reg;
	assign avg_o = out_reg;

	a_avg_clear: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE15
		clear_i |=> (cnt_reg == 2'h0 && acc_reg == '0)) else $error("Average not cleared");
endmodule

// >>> dacc_host_model.sv
// Host controller model driving the start and powerdown/reset pins
`timescale 1ns/100ps
module dacc_host_model (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Requests from the bench
	input  wire logic start_req_i,
	input  wire logic abort_req_i,
	// Pins toward the core
	output logic      conversion_start_pin_o,
	output logic      powerdown_reset_pin_o
);
	logic [2:0] st_cnt_reg;
	logic [2:0] pd_cnt_reg;

	// Pulses last four cycles so the two-stage synchronizer always sees them
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_cnt_reg <= 3'h0;
			pd_cnt_reg <= 3'h0;
		end else begin
			st_cnt_reg <= start_req_i ? 3'h4 : ((st_cnt_reg != 3'h0) ? st_cnt_reg - 3'h1 : 3'h0);
			pd_cnt_reg <= abort_req_i ? 3'h4 : ((pd_cnt_reg != 3'h0) ? pd_cnt_reg - 3'h1 : 3'h0);
		end
	end
	assign conversion_start_pin_o = (st_cnt_reg != 3'h0);
	assign powerdown_reset_pin_o  = (pd_cnt_reg == 3'h0);
endmodule

// >>> tb_dual_adc_conversion_core.sv
// Self-checking bench for the dual converter conversion core
`timescale 1ns/100ps
module tb_dual_adc_conversion_core;
	logic        clk = 1'b0, rst = 1'b1, st_req = 1'b0, ab_req = 1'b0, ofs = 1'b0;
	logic        st_pin, pd_pin, sw, done, rdy;
	logic [1:0]  avg = 2'h0;
	logic [17:0] raw_a = 18'h0_0000, raw_b = 18'h0_0000;
	logic [7:0]  ofs_o;
	logic [15:0] da, db, ga, gb;
	logic        rdy14;
	logic [13:0] da14, db14, ga14, gb14;
	int          mismatches = 0, checks_done = 0, nd, nr, swlow;

	initial forever #2 clk = ~clk;

	dacc_host_model u_host (.core_clk_i(clk), .rst_i(rst), .start_req_i(st_req), .abort_req_i(ab_req),
		.conversion_start_pin_o(st_pin), .powerdown_reset_pin_o(pd_pin));
	dacc_core #(.RES(16), .CONV_CYCLES(8)) u_dut (.core_clk_i(clk), .rst_i(rst),
		.conversion_start_pin_i(st_pin), .powerdown_reset_pin_i(pd_pin),
		.averaging_select_field_i(avg), .mid_reference_offset_enable_i(ofs), .raw_a_i(raw_a), .raw_b_i(raw_b),
		.sample_switch_closed_o(sw), .mid_reference_buffer_offset_o(ofs_o), .conversion_done_internal_o(done),
		.ready_o(rdy), .data_a_o(da), .data_b_o(db));
	// Narrow variant shares the pins, so both resolutions see one stimulus
	dacc_core #(.RES(14), .CONV_CYCLES(8)) u_dut14 (.core_clk_i(clk), .rst_i(rst),
		.conversion_start_pin_i(st_pin), .powerdown_reset_pin_i(pd_pin),
		.averaging_select_field_i(avg), .mid_reference_offset_enable_i(ofs), .raw_a_i(raw_a[15:0]),
		.raw_b_i(raw_b[15:0]), .sample_switch_closed_o(), .mid_reference_buffer_offset_o(),
		.conversion_done_internal_o(), .ready_o(rdy14), .data_a_o(da14), .data_b_o(db14));

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One start pulse, then a fixed watch window longer than the minimum spacing
	task conv(input logic [17:0] a, input logic [17:0] b);
		nd = 0;
		nr = 0;
		swlow = 0;
		raw_a = a;
		raw_b = b;
		st_req = 1'b1;
		cyc(1);
		st_req = 1'b0;
		repeat (24) begin
			cyc(1);
			if (sw === 1'b0 && nd == 0) swlow = 1;
			if (done === 1'b1) nd++;
			if (rdy === 1'b1) begin
				nr++;
				ga = da;
				gb = db;
			end
			if (rdy14 === 1'b1) begin
				ga14 = da14;
				gb14 = db14;
			end
		end
	endtask

	task t_plain;
		avg = 2'h0;
		conv(18'h0_0064, 18'h3_FFFB);
		chk(nd, 1);
		chk(nr, 1);
		chk(swlow, 1);
		chk(sw, 1);
		chk(ga, 16'h0064);
		chk(gb, 16'hFFFB);
		$display("test plain done");
	endtask

	task t_sat;
		avg = 2'h1;
		conv(18'h0_8000, 18'h3_7FFF);
		chk(ga, 16'h7FFF);
		chk(gb, 16'h8000);
		chk(ga14, 14'h2000);
		chk(gb14, 14'h1FFF);
		conv(18'h0_0000, 18'h0_0000);
		chk({ga, gb}, 32'h0000_0000);
		chk({ga14, gb14}, 28'h000_0000);
		$display("test saturation done");
	endtask

	task t_ofs;
		ofs = 1'b1;
		cyc(3);
		chk(ofs_o, 8'h64);
		ofs = 1'b0;
		cyc(3);
		chk(ofs_o, 8'h00);
		$display("test offset done");
	endtask

	task t_avg;
		avg = 2'h2;
		cyc(2);
		conv(18'h0_0003, 18'h3_FFFD);
		chk(nr, 0);
		conv(18'h0_0004, 18'h3_FFFC);
		chk(nr, 1);
		chk({ga, gb}, 32'h0003_FFFC);
		conv(18'h0_00C8, 18'h0_00C8);
		avg = 2'h3;
		cyc(2);
		conv(18'h0_0001, 18'h3_FFFF);
		conv(18'h0_0002, 18'h3_FFFF);
		conv(18'h0_0003, 18'h3_FFFF);
		chk(nr, 0);
		conv(18'h0_0005, 18'h3_FFFE);
		chk(nr, 1);
		chk({ga, gb}, 32'h0002_FFFE);
		$display("test averaging done");
	endtask

	// Abort lands while the core is still converting
	task t_abort;
		avg = 2'h0;
		st_req = 1'b1;
		cyc(1);
		st_req = 1'b0;
		cyc(2);
		ab_req = 1'b1;
		cyc(1);
		ab_req = 1'b0;
		nd = 0;
		repeat (30) begin
			cyc(1);
			if (done === 1'b1) nd++;
		end
		chk(nd, 0);
		conv(18'h0_0011, 18'h0_0022);
		chk({ga, gb}, 32'h0011_0022);
		$display("test abort done");
	endtask

	initial begin
		cyc(3);
		rst = 1'b0;
		cyc(6);
		t_plain();
		t_sat();
		t_ofs();
		t_avg();
		t_abort();
		tally_and_finish();
	end

	initial begin
		#12000;
		mismatches++;
		tally_and_finish();
	end
endmodule
